// *** verilog/fss_top.sv ***
// Synthesizer, modulation and data slicer setup block with an AHB-Lite register slave.
//
// Summary of operation
// - Two frequency words are held; the select bit picks the one in use.
// - Each word is three bytes; bit zero of the low byte enables dither.
// - Low band ratio is three quarters plus word-with-half-dither over 32768.
// - High band ratio is three halves plus word-with-half-dither over 16384.
// - Band bit 0 selects 402-470 MHz, 1 selects 804-960 MHz.
// - Reference is crystal divided by divider field plus one, field 1 to 7.
// - Deviation is reference times mantissa times two to exponent minus 16 or 15.
// - FSK zero sits below the carrier by the deviation, one above it.
// - A zero deviation mantissa selects on-off keying.
// - The shaping bit applies Gaussian filtering to the modulating signal.
// - IF is crystal over eight times IF divider plus one, ADC clock over four.
// - Channel filter bandwidth is 307.2 kHz over decimation field plus one.
// - Slicer level is the mean of detected minimum and maximum frequency.
// - A shift beyond the expected deviation records a transition and re-averages.
// - At least three transitions are needed before a slicing level exists.
// - Averaging length field sets averaging; zero assumes symmetry about the IF.
//
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module fss_top #(
	parameter int SAMPLE_W = 16
) (
	input wire logic I_CLK,
	input wire logic I_RESETN,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	input wire logic I_TX_DATA,
	input wire logic I_TX_STROBE,
	input wire logic signed [SAMPLE_W-1:0] I_RX_FREQ,
	input wire logic I_RX_VALID,
	output logic [31:0] O_HRDATA,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	output logic [26:0] O_PLL_RATIO,
	output logic O_DITHER,
	output logic O_BAND_HIGH,
	output logic O_REF_TICK,
	output logic O_ADC_TICK,
	output logic O_IF_TICK,
	output logic [11:0] O_DEV_RATIO,
	output logic signed [15:0] O_TX_DEV_OFFSET,
	output logic O_TX_CARRIER_ON,
	output logic O_FILTER_BYPASS,
	output logic [5:0] O_DECIM_RATIO,
	output logic O_RX_BIT,
	output logic O_RX_BIT_VALID,
	output logic O_SLICE_READY,
	output logic signed [SAMPLE_W-1:0] O_SLICE_LEVEL
);
	function automatic logic [26:0] pll_ratio(input logic [23:0] w, input logic hb);
		pll_ratio = hb ? fss_pkg::HIGH_BASE + {2'h0, w, 1'b0} : fss_pkg::LOW_BASE + {3'h0, w};
	endfunction

	function automatic logic [11:0] dev_ratio(input logic [3:0] m, input logic [2:0] x,
		input logic hb);
		dev_ratio = ({8'h00, m} << x) << hb;
	endfunction

	logic [23:0] first_freq_word_reg, first_freq_word_next;
	logic [23:0] second_freq_word_reg, second_freq_word_next;
	logic [15:0] control_reg, control_next;
	logic [6:0] deviation_reg, deviation_next;
	logic [12:0] slicer_tuning_reg, slicer_tuning_next;
	logic [7:0] addr_reg, addr_next;
	logic wr_reg, wr_next;
	logic [31:0] rdata_next, status;
	logic word_sel, band_choice, shape_on, rx_enable;
	logic [2:0] ref_div, if_div, tx_dev_exponent;
	logic [3:0] tx_dev_mantissa, rx_expected_mantissa;
	logic [1:0] rx_expected_exponent, slicer_average_length;
	logic [4:0] decimation_factor;
	logic [23:0] sel_word;
	logic ook;

	assign word_sel = control_reg[fss_pkg::CTRL_SEL];
	assign band_choice = control_reg[fss_pkg::CTRL_BAND];
	assign shape_on = control_reg[fss_pkg::CTRL_SHAPE];
	assign rx_enable = control_reg[fss_pkg::CTRL_RXEN];
	assign ref_div = control_reg[fss_pkg::CTRL_REFDIV +: 3];
	assign if_div = control_reg[fss_pkg::CTRL_IFDIV +: 3];
	assign tx_dev_mantissa = deviation_reg[fss_pkg::DEV_MANT +: 4];
	assign tx_dev_exponent = deviation_reg[fss_pkg::DEV_EXP +: 3];
	assign rx_expected_exponent = slicer_tuning_reg[fss_pkg::SL_EXP +: 2];
	assign rx_expected_mantissa = slicer_tuning_reg[fss_pkg::SL_MANT +: 4];
	assign slicer_average_length = slicer_tuning_reg[fss_pkg::SL_AVG +: 2];
	assign decimation_factor = slicer_tuning_reg[fss_pkg::SL_DEC +: 5];
	assign sel_word = word_sel ? second_freq_word_reg : first_freq_word_reg;
	assign ook = tx_dev_mantissa == 4'h0;

	// Writes land in the data phase; reading from the next values forwards a
	// write that is still completing to a read of the same word.
	always_comb
	begin
		first_freq_word_next = first_freq_word_reg;
		second_freq_word_next = second_freq_word_reg;
		control_next = control_reg;
		deviation_next = deviation_reg;
		slicer_tuning_next = slicer_tuning_reg;
		addr_next = addr_reg;
		wr_next = 1'b0;
		rdata_next = O_HRDATA;
		if (wr_reg)
		begin
			case (addr_reg)
				fss_pkg::OFF_FIRST_WORD: first_freq_word_next = I_HWDATA[23:0];
				fss_pkg::OFF_SECOND_WORD: second_freq_word_next = I_HWDATA[23:0];
				fss_pkg::OFF_CONTROL: control_next = I_HWDATA[15:0] & 16'h771f;
				fss_pkg::OFF_DEVIATION: deviation_next = I_HWDATA[6:0];
				fss_pkg::OFF_SLICER_TUNING: slicer_tuning_next = I_HWDATA[12:0];
				default: ;
			endcase
		end
		if (I_HSEL && I_HTRANS[1] && I_HREADY)
		begin
			addr_next = I_HADDR[7:0];
			wr_next = I_HWRITE;
			case (I_HADDR[7:0])
				fss_pkg::OFF_FIRST_WORD: rdata_next = {8'h00, first_freq_word_next};
				fss_pkg::OFF_SECOND_WORD: rdata_next = {8'h00, second_freq_word_next};
				fss_pkg::OFF_CONTROL: rdata_next = {16'h0000, control_next};
				fss_pkg::OFF_DEVIATION: rdata_next = {25'h0, deviation_next};
				fss_pkg::OFF_SLICER_TUNING: rdata_next = {19'h0, slicer_tuning_next};
				fss_pkg::OFF_STATUS: rdata_next = status;
				default: rdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
		begin
			first_freq_word_reg <= fss_pkg::WORD_RESET;
			second_freq_word_reg <= fss_pkg::WORD_RESET;
			control_reg <= fss_pkg::CTRL_RESET;
			deviation_reg <= fss_pkg::DEV_RESET;
			slicer_tuning_reg <= fss_pkg::SLICE_RESET;
			addr_reg <= 8'h00;
			wr_reg <= 1'b0;
			O_HRDATA <= 32'h00000000;
			O_HREADYOUT <= 1'b1;
			O_HRESP <= 1'b0;
		end
		else
		begin
			first_freq_word_reg <= first_freq_word_next;
			second_freq_word_reg <= second_freq_word_next;
			control_reg <= control_next;
			deviation_reg <= deviation_next;
			slicer_tuning_reg <= slicer_tuning_next;
			addr_reg <= addr_next;
			wr_reg <= wr_next;
			O_HRDATA <= rdata_next;
			O_HREADYOUT <= 1'b1;
			O_HRESP <= 1'b0;
		end
	end

	// Reference, ADC and IF strobes, all derived from the crystal clock.
	logic [2:0] ref_cnt_reg, ref_cnt_next;
	logic [3:0] adc_cnt_reg, adc_cnt_next;
	logic [1:0] if_cnt_reg, if_cnt_next;
	logic ref_tick, adc_tick, if_tick;
	always_comb
	begin
		ref_tick = ref_cnt_reg == ref_div;
		ref_cnt_next = ref_tick ? 3'h0 : ref_cnt_reg + 3'h1;
		adc_tick = adc_cnt_reg == {if_div, 1'b1};
		adc_cnt_next = adc_tick ? 4'h0 : adc_cnt_reg + 4'h1;
		if_tick = adc_tick && if_cnt_reg == fss_pkg::IF_PER_ADC_LAST;
		if_cnt_next = adc_tick ? if_cnt_reg + 2'h1 : if_cnt_reg;
	end

	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
		begin
			ref_cnt_reg <= 3'h0;
			adc_cnt_reg <= 4'h0;
			if_cnt_reg <= 2'h0;
		end
		else
		begin
			ref_cnt_reg <= ref_cnt_next;
			adc_cnt_reg <= adc_cnt_next;
			if_cnt_reg <= if_cnt_next;
		end
	end

	// Shaping is a 1-3-3-1 weighting of the last four symbols; unshaped
	// symbols get the full weight of 8 so both paths share one scaler.
	logic [3:0] hist_reg, hist_next;
	logic [3:0] weight;
	logic [11:0] dev_now;
	logic signed [17:0] prod;
	always_comb
	begin
		hist_next = I_TX_STROBE ? {hist_reg[2:0], I_TX_DATA} : hist_reg;
		dev_now = dev_ratio(tx_dev_mantissa, tx_dev_exponent, band_choice);
		if (shape_on)
			weight = {3'h0, hist_reg[0]} + 4'(3 * hist_reg[1]) + 4'(3 * hist_reg[2])
				+ {3'h0, hist_reg[3]};
		else
			weight = {hist_reg[0], 3'h0};
		prod = $signed({1'b0, dev_now}) * ($signed({1'b0, weight}) - 5'sd4);
	end

	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
			hist_reg <= 4'h0;
		else
			hist_reg <= hist_next;
	end

	// Slicer state.
	logic signed [SAMPLE_W-1:0] ref_reg, ref_next, min_reg, min_next, max_reg, max_next;
	logic signed [SAMPLE_W-1:0] level_reg, level_next, mean;
	logic signed [SAMPLE_W:0] diff, thr, step;
	logic [1:0] trans_reg, trans_next;
	logic seen_reg, seen_next, bit_next, up, dn;
	always_comb
	begin
		ref_next = ref_reg;
		min_next = min_reg;
		max_next = max_reg;
		trans_next = trans_reg;
		seen_next = seen_reg;
		bit_next = O_RX_BIT;
		thr = $signed((SAMPLE_W+1)'(rx_expected_mantissa) << rx_expected_exponent);
		diff = I_RX_FREQ - ref_reg;
		up = I_RX_VALID && seen_reg && diff > thr;
		dn = I_RX_VALID && seen_reg && diff < -thr;
		if (I_RX_VALID)
		begin
			seen_next = 1'b1;
			if (!seen_reg || up || dn)
				ref_next = I_RX_FREQ;
			if (up)
				max_next = I_RX_FREQ;
			if (dn)
				min_next = I_RX_FREQ;
			if ((up || dn) && trans_reg != fss_pkg::MIN_TRANS)
				trans_next = trans_reg + 2'h1;
			bit_next = I_RX_FREQ > level_reg;
		end
		// Both ends are sign-extended so an offset below the IF keeps its sign.
		mean = SAMPLE_W'(($signed({min_next[SAMPLE_W-1], min_next})
			+ $signed({max_next[SAMPLE_W-1], max_next})) >>> 1);
		step = (mean - level_reg) >>> (slicer_average_length - 2'h1);
		level_next = level_reg;
		if (slicer_average_length == 2'h0)
			level_next = '0;
		else if ((up || dn) && trans_next == fss_pkg::MIN_TRANS)
			level_next = trans_reg != fss_pkg::MIN_TRANS ? mean
				: level_reg + SAMPLE_W'(step);
		if (!rx_enable)
		begin
			ref_next = '0;
			min_next = '0;
			max_next = '0;
			level_next = '0;
			trans_next = 2'h0;
			seen_next = 1'b0;
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
		begin
			ref_reg <= '0;
			min_reg <= '0;
			max_reg <= '0;
			level_reg <= '0;
			trans_reg <= 2'h0;
			seen_reg <= 1'b0;
		end
		else
		begin
			ref_reg <= ref_next;
			min_reg <= min_next;
			max_reg <= max_next;
			level_reg <= level_next;
			trans_reg <= trans_next;
			seen_reg <= seen_next;
		end
	end

	assign status = {12'h000, ook, O_SLICE_READY, trans_reg, 16'(level_reg)};

	// Output registers.
	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
		begin
			O_PLL_RATIO <= fss_pkg::LOW_BASE;
			O_DITHER <= 1'b0;
			O_BAND_HIGH <= 1'b0;
			O_REF_TICK <= 1'b0;
			O_ADC_TICK <= 1'b0;
			O_IF_TICK <= 1'b0;
			O_DEV_RATIO <= 12'h000;
			O_TX_DEV_OFFSET <= 16'sh0000;
			O_TX_CARRIER_ON <= 1'b0;
			O_FILTER_BYPASS <= 1'b0;
			O_DECIM_RATIO <= 6'h01;
			O_RX_BIT <= 1'b0;
			O_RX_BIT_VALID <= 1'b0;
			O_SLICE_READY <= 1'b0;
			O_SLICE_LEVEL <= '0;
		end
		else
		begin
			O_PLL_RATIO <= pll_ratio(sel_word, band_choice);
			O_DITHER <= sel_word[0];
			O_BAND_HIGH <= band_choice;
			O_REF_TICK <= ref_tick;
			O_ADC_TICK <= adc_tick;
			O_IF_TICK <= if_tick;
			O_DEV_RATIO <= dev_now;
			O_TX_DEV_OFFSET <= ook ? 16'sh0000 : 16'(prod >>> 2);
			O_TX_CARRIER_ON <= ook ? hist_reg[0] : 1'b1;
			O_FILTER_BYPASS <= control_reg[fss_pkg::CTRL_BYPASS];
			O_DECIM_RATIO <= {1'b0, decimation_factor} + 6'h01;
			O_RX_BIT <= bit_next;
			O_RX_BIT_VALID <= I_RX_VALID && rx_enable;
			O_SLICE_READY <= rx_enable && (slicer_average_length == 2'h0
				|| trans_next == fss_pkg::MIN_TRANS);
			O_SLICE_LEVEL <= level_next;
		end
	end

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RESETN);

	a_word_ratio: assert property (
		##1 O_PLL_RATIO == pll_ratio($past(sel_word), $past(band_choice)))
		else $error("ratio does not follow selected word");
	a_high_even: assert property (band_choice |=> !O_PLL_RATIO[0])
		else $error("high band ratio has odd fraction");
	a_ref_period: assert property (
		(O_REF_TICK && ref_div == 3'h3 && $stable(ref_div)) ##1 (ref_div == 3'h3)[*4]
		|-> !$past(O_REF_TICK, 1) && !$past(O_REF_TICK, 2) && !$past(O_REF_TICK, 3)
		&& O_REF_TICK)
		else $error("reference strobe period wrong");
	a_if_period: assert property (
		(O_IF_TICK && if_div == 3'h0) ##1 (if_div == 3'h0)[*7] |=> O_IF_TICK)
		else $error("IF strobe period wrong");
	a_dev_scale: assert property (
		band_choice && deviation_reg == 7'h31 |=> O_DEV_RATIO == 12'h010)
		else $error("deviation scaling wrong");
	a_ook_zero: assert property (ook |=> O_TX_DEV_OFFSET == 16'sh0000)
		else $error("offset present in on-off keying");
	a_fsk_sign: assert property (
		!ook && !shape_on && hist_reg[0] |=> O_TX_DEV_OFFSET > 16'sh0000)
		else $error("one symbol not above carrier");
	a_slice_gate: assert property (
		O_SLICE_READY && $past(slicer_average_length) != 2'h0 |-> trans_reg == fss_pkg::MIN_TRANS)
		else $error("slicing level before three transitions");
	a_clear_on_off: assert property (
		!rx_enable |=> trans_reg == 2'h0 && !O_SLICE_READY)
		else $error("slicer history not cleared");
	a_mean_level: assert property (
		(up || dn) && rx_enable && slicer_average_length == 2'h1 && trans_next == 2'h3
		|=> level_reg == SAMPLE_W'(($signed({min_reg[SAMPLE_W-1], min_reg})
		+ $signed({max_reg[SAMPLE_W-1], max_reg})) >>> 1))
		else $error("level is not the mean");
	a_avg_off: assert property (slicer_average_length == 2'h0 |=> O_SLICE_LEVEL == '0)
		else $error("level not zero with averaging off");
	c_slice_ready: cover property (rx_enable ##1 $rose(O_SLICE_READY));
	c_ook_tx: cover property (ook && I_TX_STROBE);
	c_bus_write: cover property (wr_reg && addr_reg == fss_pkg::OFF_CONTROL);
endmodule

// *** verilog/fss_pkg.sv ***
// Register map, field positions, reset values and scaling constants.
package fss_pkg;
	localparam logic [7:0] OFF_FIRST_WORD = 8'h00;
	localparam logic [7:0] OFF_SECOND_WORD = 8'h04;
	localparam logic [7:0] OFF_CONTROL = 8'h08;
	localparam logic [7:0] OFF_DEVIATION = 8'h0c;
	localparam logic [7:0] OFF_SLICER_TUNING = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam int CTRL_SEL = 0;
	localparam int CTRL_BAND = 1;
	localparam int CTRL_SHAPE = 2;
	localparam int CTRL_BYPASS = 3;
	localparam int CTRL_RXEN = 4;
	localparam int CTRL_REFDIV = 8;
	localparam int CTRL_IFDIV = 12;
	localparam int DEV_MANT = 0;
	localparam int DEV_EXP = 4;
	localparam int SL_EXP = 0;
	localparam int SL_MANT = 2;
	localparam int SL_AVG = 6;
	localparam int SL_DEC = 8;
	localparam logic [23:0] WORD_RESET = 24'h000000;
	localparam logic [15:0] CTRL_RESET = 16'h0100;
	localparam logic [6:0] DEV_RESET = 7'h00;
	localparam logic [12:0] SLICE_RESET = 13'h0000;
	// Ratios to the reference carry 16 fraction bits: 3/4 and 3/2.
	localparam logic [26:0] LOW_BASE = 27'h000c000;
	localparam logic [26:0] HIGH_BASE = 27'h0018000;
	localparam logic [1:0] IF_PER_ADC_LAST = 2'h3;
	localparam logic [1:0] MIN_TRANS = 2'h3;
endpackage

// *** verification/fss_peer_radio.sv ***
// Far transmitter model that feeds demodulated frequency samples to the slicer.
`timescale 1ns/1ps
module fss_peer_radio (
	input wire logic i_clk,
	input wire logic i_run,
	input wire logic signed [15:0] i_offset,
	input wire logic signed [15:0] i_dev,
	output logic signed [15:0] o_freq,
	output logic o_valid,
	output logic o_bit
);
	logic [3:0] cnt;
	initial
	begin
		cnt = 4'h0;
		o_freq = 16'h0000;
		o_valid = 1'b0;
		o_bit = 1'b1;
	end
	always @(posedge i_clk)
	begin
		if (i_run && cnt >= 4'h5)
		begin
			cnt <= 4'h0;
			// The alternating preamble gives the slicer a transition on every symbol after the first.
			o_bit <= ~o_bit;
			o_freq <= o_bit ? i_offset - i_dev : i_offset + i_dev;
			o_valid <= 1'b1;
		end
		else
		begin
			cnt <= cnt + 4'h1;
			// Between samples the line carries no meaning, so it is scrambled.
			o_freq <= ~o_freq;
			o_valid <= 1'b0;
		end
	end
endmodule

// *** verification/fss_top_bench.sv ***
// Self-checking bench for the synthesizer and slicer setup block.
`timescale 1ns/1ps
module fss_top_bench;
	logic I_CLK = 1'b0;
	logic I_RESETN = 1'b0;
	logic I_HSEL = 1'b0;
	logic [31:0] I_HADDR = 32'h0;
	logic [1:0] I_HTRANS = 2'h0;
	logic I_HWRITE = 1'b0;
	logic [31:0] I_HWDATA = 32'h0;
	logic I_TX_DATA = 1'b0;
	logic I_TX_STROBE = 1'b0;
	logic [31:0] O_HRDATA;
	logic [26:0] O_PLL_RATIO;
	logic [11:0] O_DEV_RATIO;
	logic [5:0] O_DECIM_RATIO;
	logic signed [15:0] O_TX_DEV_OFFSET, O_SLICE_LEVEL, rx_freq, offs;
	logic O_HREADYOUT, O_HRESP, O_DITHER, O_BAND_HIGH, O_REF_TICK, O_ADC_TICK, O_IF_TICK;
	logic O_TX_CARRIER_ON, O_FILTER_BYPASS, O_RX_BIT, O_RX_BIT_VALID, O_SLICE_READY;
	logic rx_valid, peer_bit;
	logic run = 1'b0;
	logic arm = 1'b0;
	logic [31:0] seed = 32'h000105c2;
	logic [31:0] x, wa, wb, w;
	logic [6:0] dv;
	logic [4:0] dc;
	logic [15:0] e;
	logic [3:0] hist;
	int fails = 0;
	int n_tests = 0;
	int cycles = 0;
	int nsamp = 0;
	int n, s0;
	fss_top #(.SAMPLE_W(16)) u_fss_top (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_HSEL(I_HSEL),
		.I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HSIZE(3'h2),
		.I_HWDATA(I_HWDATA), .I_HREADY(O_HREADYOUT), .I_TX_DATA(I_TX_DATA),
		.I_TX_STROBE(I_TX_STROBE), .I_RX_FREQ(rx_freq), .I_RX_VALID(rx_valid),
		.O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
		.O_PLL_RATIO(O_PLL_RATIO), .O_DITHER(O_DITHER), .O_BAND_HIGH(O_BAND_HIGH),
		.O_REF_TICK(O_REF_TICK), .O_ADC_TICK(O_ADC_TICK), .O_IF_TICK(O_IF_TICK),
		.O_DEV_RATIO(O_DEV_RATIO), .O_TX_DEV_OFFSET(O_TX_DEV_OFFSET),
		.O_TX_CARRIER_ON(O_TX_CARRIER_ON), .O_FILTER_BYPASS(O_FILTER_BYPASS),
		.O_DECIM_RATIO(O_DECIM_RATIO), .O_RX_BIT(O_RX_BIT), .O_RX_BIT_VALID(O_RX_BIT_VALID),
		.O_SLICE_READY(O_SLICE_READY), .O_SLICE_LEVEL(O_SLICE_LEVEL));
	fss_peer_radio u_fss_peer_radio (.i_clk(I_CLK), .i_run(run), .i_offset(offs),
		.i_dev(16'h0190), .o_freq(rx_freq), .o_valid(rx_valid), .o_bit(peer_bit));
	always #25 I_CLK = ~I_CLK;
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] ratio(input logic band, input logic [31:0] wd);
		return band ? 32'h00018000 + (wd << 1) : 32'h0000c000 + wd;
	endfunction
	function automatic logic signed [15:0] shaped(input logic [3:0] h, input int d);
		int wt;
		wt = h[0] + 3 * h[1] + 3 * h[2] + h[3];
		return 16'((wt - 4) * d / 4);
	endfunction
	function automatic logic tick(input int s);
		return s == 0 ? O_REF_TICK : s == 1 ? O_ADC_TICK : O_IF_TICK;
	endfunction
	task automatic final_report;
		if (fails == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge I_CLK);
		I_HSEL <= 1'b1;
		I_HTRANS <= 2'h2;
		I_HADDR <= {24'h000000, a};
		I_HWRITE <= wr;
		do
			@(posedge I_CLK);
		while (O_HREADYOUT !== 1'b1);
		I_HSEL <= 1'b0;
		I_HTRANS <= 2'h0;
		I_HWDATA <= wd;
		do
			@(posedge I_CLK);
		while (O_HREADYOUT !== 1'b1);
		rd = O_HRDATA;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, x);
		// The configuration outputs follow one cycle after the write lands.
		repeat (3) @(posedge I_CLK);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] ex);
		bus(1'b0, a, 32'h0, x);
		check(x, ex);
	endtask
	task automatic sym(input logic b);
		I_TX_DATA <= b;
		I_TX_STROBE <= 1'b1;
		@(posedge I_CLK);
		I_TX_STROBE <= 1'b0;
		repeat (2) @(posedge I_CLK);
	endtask
	task automatic per(input int s, output int p);
		p = 0;
		while (tick(s) !== 1'b1 && p < 200)
		begin
			@(posedge I_CLK);
			p++;
		end
		p = 0;
		do
		begin
			@(posedge I_CLK);
			p++;
		end
		while (tick(s) !== 1'b1 && p < 200);
	endtask
	always @(posedge I_CLK)
	begin
		cycles++;
		if (rx_valid === 1'b1)
			nsamp++;
		if (arm && O_RX_BIT_VALID === 1'b1)
			check(O_RX_BIT, peer_bit);
		// Generous ceiling: the whole sequence needs well under a tenth of it.
		if (cycles == 30000)
		begin
			fails++;
			final_report();
		end
	end
	initial
	begin
		repeat (16) @(posedge I_CLK);
		I_RESETN <= 1'b1;
		rdchk(fss_pkg::OFF_CONTROL, 32'h00000100);
		rdchk(fss_pkg::OFF_DEVIATION, 32'h0);
		check(O_PLL_RATIO, 32'h0000c000);
		check(O_DECIM_RATIO, 32'h1);
		check(O_HRESP, 1'b0);
		wr(8'h18, 32'hffffffff);
		rdchk(8'h18, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			seed = lfsr_next(lfsr_next(seed));
			wa = i == 7 ? 32'h00ffffff : {8'h00, seed[23:0]};
			if (i == 6)
				wa = {8'h00, wa[23:0] - 24'h0007dc}; // Receive word sits one IF step low.
			seed = lfsr_next(lfsr_next(lfsr_next(seed)));
			wb = {8'h00, seed[31:8]};
			wr(fss_pkg::OFF_FIRST_WORD, wa);
			wr(fss_pkg::OFF_SECOND_WORD, wb);
			wr(fss_pkg::OFF_CONTROL, {28'h0000010, 2'h0, i[1:0]});
			w = i[0] ? wb : wa;
			rdchk(fss_pkg::OFF_SECOND_WORD, wb);
			check(O_PLL_RATIO, ratio(i[1], w));
			check(O_DITHER, w[0]);
			check(O_BAND_HIGH, i[1]);
		end
		for (int i = 0; i < 8; i++)
		begin
			seed = lfsr_next(seed);
			dv = i == 1 ? 7'h7f : i == 3 ? 7'h31 : seed[6:0];
			if (i == 0)
				dv[3:0] = 4'h0;
			wr(fss_pkg::OFF_CONTROL, {30'h00000040, i[0], 1'b0});
			wr(fss_pkg::OFF_DEVIATION, {25'h0, dv});
			e = 16'(dv[3:0]) << ({1'b0, dv[6:4]} + i[0]);
			check(O_DEV_RATIO, e);
			bus(1'b0, fss_pkg::OFF_STATUS, 32'h0, x);
			check(x[19], dv[3:0] == 4'h0);
			sym(1'b1);
			check(O_TX_CARRIER_ON, 1'b1);
			if (dv[3:0] != 4'h0)
				check(O_TX_DEV_OFFSET, e);
			sym(1'b0);
			check(O_TX_CARRIER_ON, dv[3:0] != 4'h0);
			if (dv[3:0] != 4'h0)
				check(O_TX_DEV_OFFSET, -e);
		end
		wr(fss_pkg::OFF_CONTROL, 32'h00000104);
		wr(fss_pkg::OFF_DEVIATION, 32'h00000004);
		hist = 4'h0;
		for (int i = 0; i < 8; i++)
		begin
			sym(i > 3);
			hist = {hist[2:0], i > 3};
			if (i >= 3)
				check(O_TX_DEV_OFFSET, shaped(hist, 4));
		end
		for (int k = 0; k < 8; k++)
		begin
			seed = lfsr_next(seed);
			wr(fss_pkg::OFF_CONTROL, {17'h0, k[2:0], 1'b0, k == 0 ? 3'h7 : k[2:0], 4'h0, k[0], 3'h0});
			dc = k == 1 ? 5'h18 : k == 2 ? 5'h0f : seed[4:0];
			wr(fss_pkg::OFF_SLICER_TUNING, {19'h0, dc, 8'h00});
			check(O_DECIM_RATIO, dc + 6'h01);
			check(O_FILTER_BYPASS, k[0]);
			per(0, n);
			check(n, k == 0 ? 8 : k + 1);
			per(1, n);
			check(n, 2 * (k + 1));
			per(2, n);
			check(n, 8 * (k + 1));
		end
		seed = lfsr_next(seed);
		offs = {{5{seed[10]}}, seed[10:0]};
		wr(fss_pkg::OFF_SLICER_TUNING, 32'h00000056);
		wr(fss_pkg::OFF_CONTROL, 32'h00000110);
		s0 = nsamp;
		run <= 1'b1;
		while (nsamp < s0 + 3)
			@(posedge I_CLK);
		repeat (2) @(posedge I_CLK);
		check(O_SLICE_READY, 1'b0);
		while (nsamp < s0 + 4)
			@(posedge I_CLK);
		repeat (2) @(posedge I_CLK);
		check(O_SLICE_READY, 1'b1);
		check(O_SLICE_LEVEL, offs);
		arm <= 1'b1;
		repeat (60) @(posedge I_CLK);
		arm <= 1'b0;
		run <= 1'b0;
		rdchk(fss_pkg::OFF_STATUS, {13'h0, 3'h7, offs});
		wr(fss_pkg::OFF_CONTROL, 32'h00000100);
		bus(1'b0, fss_pkg::OFF_STATUS, 32'h0, x);
		check(x[18:16], 3'h0);
		wr(fss_pkg::OFF_SLICER_TUNING, 32'h00000016);
		wr(fss_pkg::OFF_CONTROL, 32'h00000110);
		check(O_SLICE_READY, 1'b1);
		check(O_SLICE_LEVEL, 32'h0);
		final_report();
	end
endmodule
